// ---- design/gaf_decoder.sv ----
// Summary of operation
// - guest access only M, HS, or U with enable
// - guest access uses virtualized translation
// - privilege select: 0 guest user, 1 guest supervisor
// - always two-stage, user-memory permit ignored
// - host exec-readable both stages, guest copy first
// - all load widths and four store widths
// - rv32: unsigned word, double load/store invalid
// - exec-perm load needs execute, pma needs exec+read
// - exec-perm load faults report as loads
// - rv32 exec-perm unsigned word acts as word
// - virt gives virtual fault, user without enable illegal
// - guest-stage fence only M or HS
// - guest-stage fence orders per current vm id
// - nonzero operands narrow guest-stage fence scope
// - asid bits above implemented width ignored
// - trap-vm bits never trap guest-stage fence
// - g-stage fence: M always, HS when trap-vm zero
// - g-stage fence orders all later translations
// - g-stage operands: address shifted by two, vm id
// - g-stage fence flushes matching id entries
// - vm id bits above implemented width ignored
// - fences: virt virtual, user illegal, hs with trap illegal for g-stage fence only
//
// The APB slave port and the register addresses were chosen for this implementation.
module gaf_decoder #(
  parameter int ASID_LEN = 9,
  parameter int VMID_LEN = 7
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic issue_o,
  output gaf_pkg::gaf_res_t res_o,
  output gaf_pkg::gaf_fence_t fence_o
);
  logic [31:0] ctrl_ff;
  logic [31:0] instr_ff;
  logic [31:0] rs1_ff;
  logic [31:0] rs2_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic issue_ff;
  gaf_pkg::gaf_res_t res_ff;
  gaf_pkg::gaf_fence_t fence_ff;
  gaf_pkg::gaf_res_t nxt_res;
  gaf_pkg::gaf_fence_t nxt_fence;
  logic setup;
  logic wr_acc;
  logic [31:0] rd_mux;
  logic rd_ok;

  // known register offset
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      gaf_pkg::REG_CTRL, gaf_pkg::REG_INSTR, gaf_pkg::REG_RS1, gaf_pkg::REG_RS2,
      gaf_pkg::REG_STATUS, gaf_pkg::REG_FADDR, gaf_pkg::REG_FID: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // decode one instruction against the current control state
  function automatic gaf_pkg::gaf_res_t decode(input logic [31:0] ins,
                                              input logic [31:0] c);
    gaf_pkg::gaf_res_t r;
    logic [1:0] pv;
    logic virt;
    logic rv32;
    logic sys;
    logic ls;
    logic ok;
    r = '0;
    pv = c[gaf_pkg::CTRL_PRIV +: 2];
    virt = c[gaf_pkg::CTRL_VIRT];
    rv32 = c[gaf_pkg::CTRL_RV32];
    sys = ins[6:0] == gaf_pkg::OPC_SYSTEM;
    ok = 1'b0;
    // guest load/store group: top four bits fixed, then size and direction
    ls = sys && ins[14:12] == gaf_pkg::F3_PRIVM && ins[31:28] == gaf_pkg::F7_LS_BASE;
    // size field shared by loads and stores
    r.size = ins[27:26];
    if (ls && ins[25]) begin
      // store: rs2 is data, rd must be zero
      r.is_store = 1'b1;
      ok = ins[11:7] == 5'h00 && !(rv32 && r.size == gaf_pkg::SZ_D);
    end else if (ls) begin
      // load: rs2 field picks signed, unsigned or execute-permission form
      r.is_load = 1'b1;
      case (ins[24:20])
        gaf_pkg::RS2_SIGNED: ok = !(rv32 && r.size == gaf_pkg::SZ_D);
        gaf_pkg::RS2_UNS: begin
          r.uns = 1'b1;
          ok = r.size == gaf_pkg::SZ_B || r.size == gaf_pkg::SZ_H ||
               (r.size == gaf_pkg::SZ_W && !rv32);
        end
        gaf_pkg::RS2_EXEC: begin
          r.exec_perm = 1'b1;
          r.uns = !(rv32 && r.size == gaf_pkg::SZ_W);
          ok = r.size == gaf_pkg::SZ_H || r.size == gaf_pkg::SZ_W;
        end
        default: ok = 1'b0;
      endcase
    end else if (sys && ins[14:12] == gaf_pkg::F3_PRIV && ins[11:7] == 5'h00) begin
      // fences: rd must be zero, funct7 picks the stage
      r.fence_vs = ins[31:25] == gaf_pkg::F7_VVMA;
      r.fence_g = ins[31:25] == gaf_pkg::F7_GVMA;
      ok = r.fence_vs || r.fence_g;
    end
    // legality order: undecoded first, then virtualized, then mode checks
    // an undecoded word leaves no attribute set, so nothing downstream acts
    if (!ok) begin
      r = '0;
      r.exc = gaf_pkg::EXC_ILL;
    end else if (virt) begin
      r.exc = gaf_pkg::EXC_VIRT;
    end else if (r.is_load || r.is_store) begin
      if (pv == gaf_pkg::PRIV_U && !c[gaf_pkg::CTRL_HU]) begin
        r.exc = gaf_pkg::EXC_ILL;
      end
    end else if (pv == gaf_pkg::PRIV_U) begin
      r.exc = gaf_pkg::EXC_ILL;
    end else if (r.fence_g && pv == gaf_pkg::PRIV_S && c[gaf_pkg::CTRL_TVM]) begin
      r.exc = gaf_pkg::EXC_ILL;
    end
    // guest access attributes, trap-vm ignored for guest fence
    if (r.is_load || r.is_store) begin
      r.acc_priv = c[gaf_pkg::CTRL_GUEST_ACCESS_PRIV_SEL];
      r.two_stage = 1'b1;
      r.sum_eff = 1'b0;
      r.mxr_g = c[gaf_pkg::CTRL_MXR];
      r.mxr_vs = c[gaf_pkg::CTRL_MXR] | c[gaf_pkg::CTRL_VSMXR];
      r.pma_rx = r.exec_perm;
    end
    decode = r;
  endfunction

  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i && pready_ff;

  // read data selection
  always_comb begin
    rd_ok = mapped(paddr_i);
    case (paddr_i)
      gaf_pkg::REG_CTRL: rd_mux = ctrl_ff;
      gaf_pkg::REG_INSTR: rd_mux = instr_ff;
      gaf_pkg::REG_RS1: rd_mux = rs1_ff;
      gaf_pkg::REG_RS2: rd_mux = rs2_ff;
      gaf_pkg::REG_STATUS: rd_mux = {16'h0000, res_ff};
      gaf_pkg::REG_FADDR: rd_mux = fence_ff.addr[31:0];
      gaf_pkg::REG_FID: rd_mux = {fence_ff.vmid, fence_ff.id};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait-free access phase after setup
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !rd_ok;
      if (setup && !pwrite_i) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // software writable registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= gaf_pkg::CTRL_RST;
      instr_ff <= 32'h0000_0000;
      rs1_ff <= 32'h0000_0000;
      rs2_ff <= 32'h0000_0000;
    end else if (wr_acc) begin
      case (paddr_i)
        gaf_pkg::REG_CTRL: ctrl_ff <= pwdata_i;
        gaf_pkg::REG_INSTR: instr_ff <= pwdata_i;
        gaf_pkg::REG_RS1: rs1_ff <= pwdata_i;
        gaf_pkg::REG_RS2: rs2_ff <= pwdata_i;
        default: ;
      endcase
    end
  end

  // fence scope from operands
  always_comb begin
    nxt_res = decode(pwdata_i, ctrl_ff);
    nxt_fence = '0;
    nxt_fence.vmid[VMID_LEN-1:0] = ctrl_ff[gaf_pkg::CTRL_VMID +: VMID_LEN];
    if (nxt_res.exc == gaf_pkg::EXC_NONE && nxt_res.fence_vs) begin
      nxt_fence.by_addr = pwdata_i[19:15] != 5'h00;
      nxt_fence.by_id = pwdata_i[24:20] != 5'h00;
      nxt_fence.addr = {2'h0, rs1_ff};
      nxt_fence.id[ASID_LEN-1:0] = rs2_ff[ASID_LEN-1:0];
    end else if (nxt_res.exc == gaf_pkg::EXC_NONE && nxt_res.fence_g) begin
      nxt_fence.by_addr = pwdata_i[19:15] != 5'h00;
      nxt_fence.by_id = pwdata_i[24:20] != 5'h00;
      nxt_fence.addr = {rs1_ff, 2'h0} << 0;
      nxt_fence.id[VMID_LEN-1:0] = rs2_ff[VMID_LEN-1:0];
    end
  end

  // writing the instruction register issues it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      issue_ff <= 1'b0;
      res_ff <= '0;
      fence_ff <= '0;
    end else begin
      issue_ff <= wr_acc && paddr_i == gaf_pkg::REG_INSTR;
      if (wr_acc && paddr_i == gaf_pkg::REG_INSTR) begin
        res_ff <= nxt_res;
        fence_ff <= nxt_fence;
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign issue_o = issue_ff;
  assign res_o = res_ff;
  assign fence_o = fence_ff;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property issue_from_write;
    wr_acc && paddr_i == gaf_pkg::REG_INSTR |=> issue_o;
  endproperty
  issue_pulse_a: assert property (issue_from_write) else $error("issue missing");
  virt_trap_a: assert property (issue_o && $past(ctrl_ff[gaf_pkg::CTRL_VIRT],2)
    && (res_o.is_load || res_o.is_store || res_o.fence_g || res_o.fence_vs)
    |-> res_o.exc == gaf_pkg::EXC_VIRT) else $error("virt not trapped");
  user_ill_a: assert property (issue_o && res_o.fence_g |->
    $past(ctrl_ff[gaf_pkg::CTRL_PRIV +: 2], 2) != gaf_pkg::PRIV_U
    || res_o.exc != gaf_pkg::EXC_NONE) else $error("user fence ran");
  tvm_ill_a: assert property (issue_o && res_o.fence_g && res_o.exc == gaf_pkg::EXC_NONE
    |-> !($past(ctrl_ff[gaf_pkg::CTRL_TVM], 2)
    && $past(ctrl_ff[gaf_pkg::CTRL_PRIV +: 2], 2) == gaf_pkg::PRIV_S))
    else $error("tvm not trapped");
  two_stage_a: assert property (issue_o && res_o.is_load |->
    res_o.two_stage && !res_o.sum_eff) else $error("one stage access");
  mxr_both_a: assert property (issue_o && res_o.mxr_g |-> res_o.mxr_vs)
    else $error("mxr stage mismatch");
  exec_pma_a: assert property (issue_o && res_o.exec_perm |->
    res_o.pma_rx && res_o.is_load && !res_o.is_store) else $error("exec load attr");
  rv32_d_a: assert property (issue_o && $past(ctrl_ff[gaf_pkg::CTRL_RV32], 2)
    && res_o.size == gaf_pkg::SZ_D |-> !res_o.is_load && !res_o.is_store)
    else $error("rv32 double ok");
  gpa_shift_a: assert property (issue_o && res_o.fence_g && res_o.exc == gaf_pkg::EXC_NONE
    |-> fence_o.addr[1:0] == 2'h0) else $error("gpa not shifted");
  id_mask_a: assert property (issue_o && res_o.fence_g |->
    fence_o.id[15:VMID_LEN] == '0) else $error("vmid bits kept");
  apb_ready_a: assert property (setup |=> pready_o ##1 !pready_o)
    else $error("pready timing");


  // attribute checks on every issued guest access
  // stores carry neither the unsigned nor the execute flag
  store_shape_a: assert property (issue_o && res_o.is_store |->
    !res_o.uns && !res_o.exec_perm) else $error("store shape");
  // execute-permission loads exist only for half and word
  exec_size_a: assert property (issue_o && res_o.exec_perm |->
    res_o.size == gaf_pkg::SZ_H || res_o.size == gaf_pkg::SZ_W)
    else $error("exec load size");
  // access level follows the privilege select bit at decode time
  priv_sel_a: assert property (issue_o && (res_o.is_load || res_o.is_store) |->
    res_o.acc_priv == $past(ctrl_ff[gaf_pkg::CTRL_GUEST_ACCESS_PRIV_SEL]))
    else $error("access level");
  // host exec-readable reaches the g-stage
  mxr_host_a: assert property (issue_o && (res_o.is_load || res_o.is_store) |->
    res_o.mxr_g == $past(ctrl_ff[gaf_pkg::CTRL_MXR]))
    else $error("host mxr");
  // guest copy alone affects only the guest stage
  mxr_guest_a: assert property (issue_o && res_o.is_load && !$past(ctrl_ff[gaf_pkg::CTRL_MXR])
    |-> res_o.mxr_vs == $past(ctrl_ff[gaf_pkg::CTRL_VSMXR]) && !res_o.mxr_g)
    else $error("guest mxr");
  // stores translate in two stages as well
  store_stage_a: assert property (issue_o && res_o.is_store |->
    res_o.two_stage && !res_o.sum_eff) else $error("store stage");
  // rv32 execute word load behaves as the plain word load
  rv32_exec_a: assert property (issue_o && res_o.exec_perm && res_o.size == gaf_pkg::SZ_W
    && $past(ctrl_ff[gaf_pkg::CTRL_RV32]) |-> !res_o.uns)
    else $error("rv32 exec word");

  // legality checks
  // guest access from M or HS outside virtualization never traps
  ls_allowed_a: assert property (issue_o && (res_o.is_load || res_o.is_store)
    && !$past(ctrl_ff[gaf_pkg::CTRL_VIRT])
    && $past(ctrl_ff[gaf_pkg::CTRL_PRIV +: 2]) != gaf_pkg::PRIV_U
    |-> res_o.exc == gaf_pkg::EXC_NONE) else $error("guest access refused");
  // user mode without the enable bit is illegal
  user_ls_a: assert property (issue_o && (res_o.is_load || res_o.is_store)
    && !$past(ctrl_ff[gaf_pkg::CTRL_VIRT]) && !$past(ctrl_ff[gaf_pkg::CTRL_HU])
    && $past(ctrl_ff[gaf_pkg::CTRL_PRIV +: 2]) == gaf_pkg::PRIV_U
    |-> res_o.exc == gaf_pkg::EXC_ILL) else $error("user access ran");
  // trap-vm never blocks the guest-stage fence outside user mode
  vs_fence_ok_a: assert property (issue_o && res_o.fence_vs
    && !$past(ctrl_ff[gaf_pkg::CTRL_VIRT])
    && $past(ctrl_ff[gaf_pkg::CTRL_PRIV +: 2]) != gaf_pkg::PRIV_U
    |-> res_o.exc == gaf_pkg::EXC_NONE) else $error("guest fence trapped");
  // guest-stage fence from user mode is illegal
  user_vs_fence_a: assert property (issue_o && res_o.fence_vs
    && !$past(ctrl_ff[gaf_pkg::CTRL_VIRT])
    && $past(ctrl_ff[gaf_pkg::CTRL_PRIV +: 2]) == gaf_pkg::PRIV_U
    |-> res_o.exc == gaf_pkg::EXC_ILL) else $error("user guest fence ran");
  // a refused fence carries no scope
  fence_scope_a: assert property (issue_o && res_o.exc != gaf_pkg::EXC_NONE |->
    !fence_o.by_addr && !fence_o.by_id) else $error("refused fence scope");

  // fence operand checks
  // guest-stage address passes unchanged
  vs_addr_a: assert property (issue_o && res_o.fence_vs && res_o.exc == gaf_pkg::EXC_NONE
    |-> fence_o.addr == {2'h0, $past(rs1_ff)}) else $error("guest vaddr");
  // asid keeps only the implemented bits
  vs_id_a: assert property (issue_o && res_o.fence_vs && res_o.exc == gaf_pkg::EXC_NONE
    |-> fence_o.id[ASID_LEN-1:0] == $past(rs2_ff[ASID_LEN-1:0]))
    else $error("asid value");
  asid_mask_a: assert property (issue_o && res_o.fence_vs |->
    fence_o.id[15:ASID_LEN] == '0) else $error("asid bits kept");
  // guest-stage fence is tagged with the current vm id
  vmid_tag_a: assert property (issue_o && res_o.fence_vs |->
    fence_o.vmid[VMID_LEN-1:0] == $past(ctrl_ff[gaf_pkg::CTRL_VMID +: VMID_LEN]))
    else $error("vm id tag");
  // g-stage address is the operand times four
  g_addr_a: assert property (issue_o && res_o.fence_g && res_o.exc == gaf_pkg::EXC_NONE
    |-> fence_o.addr == {$past(rs1_ff), 2'h0}) else $error("gpa value");
  // g-stage vm id keeps only the implemented bits
  g_id_a: assert property (issue_o && res_o.fence_g && res_o.exc == gaf_pkg::EXC_NONE
    |-> fence_o.id[VMID_LEN-1:0] == $past(rs2_ff[VMID_LEN-1:0]))
    else $error("vm id value");

  // issue and bus behaviour
  // results hold until the next instruction write
  res_hold_a: assert property (!(wr_acc && paddr_i == gaf_pkg::REG_INSTR) |=>
    $stable(res_o) && $stable(fence_o)) else $error("result moved");
  issue_once_a: assert property (issue_o |=> !issue_o) else $error("issue too long");
  // error flag follows the address decode of the setup cycle
  apb_err_a: assert property (pready_o |-> pslverr_o == !$past(rd_ok))
    else $error("pslverr wrong");

  exec_load_c: cover property (issue_o && res_o.exec_perm && res_o.exc == gaf_pkg::EXC_NONE);
  guest_load_c: cover property (issue_o && res_o.is_load && res_o.exc == gaf_pkg::EXC_NONE);
  guest_store_c: cover property (issue_o && res_o.is_store && res_o.exc == gaf_pkg::EXC_NONE);
  g_fence_c: cover property (issue_o && res_o.fence_g && fence_o.by_id);
  virt_exc_c: cover property (issue_o && res_o.exc == gaf_pkg::EXC_VIRT);
endmodule

// ---- design/gaf_pkg.sv ----
package gaf_pkg;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_RS1 = 8'h08;
  localparam logic [7:0] REG_RS2 = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FADDR = 8'h14;
  localparam logic [7:0] REG_FID = 8'h18;
  // ctrl field positions
  localparam int CTRL_PRIV = 0;
  localparam int CTRL_VIRT = 2;
  localparam int CTRL_HU = 3;
  localparam int CTRL_GUEST_ACCESS_PRIV_SEL = 4;
  localparam int CTRL_TVM = 5;
  localparam int CTRL_MXR = 6;
  localparam int CTRL_VSMXR = 7;
  localparam int CTRL_RV32 = 8;
  localparam int CTRL_VMID = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  // privilege levels
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  // exception outcome codes
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_ILL = 2'h1;
  localparam logic [1:0] EXC_VIRT = 2'h2;
  // instruction fields
  localparam logic [6:0] OPC_SYSTEM = 7'h73;
  localparam logic [2:0] F3_PRIVM = 3'h4;
  localparam logic [2:0] F3_PRIV = 3'h0;
  localparam logic [6:0] F7_VVMA = 7'h11;
  localparam logic [6:0] F7_GVMA = 7'h31;
  localparam logic [4:0] RS2_SIGNED = 5'h00;
  localparam logic [4:0] RS2_UNS = 5'h01;
  localparam logic [4:0] RS2_EXEC = 5'h03;
  localparam logic [3:0] F7_LS_BASE = 4'h6;
  // access sizes
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_H = 2'h1;
  localparam logic [1:0] SZ_W = 2'h2;
  localparam logic [1:0] SZ_D = 2'h3;
  localparam int GPA_SHIFT = 2;

  typedef struct packed {
    logic [1:0] exc;
    logic is_load;
    logic is_store;
    logic fence_vs;
    logic fence_g;
    logic [1:0] size;
    logic uns;
    logic exec_perm;
    logic acc_priv;
    logic two_stage;
    logic sum_eff;
    logic mxr_vs;
    logic mxr_g;
    logic pma_rx;
  } gaf_res_t;

  typedef struct packed {
    logic by_addr;
    logic by_id;
    logic [33:0] addr;
    logic [15:0] id;
    logic [15:0] vmid;
  } gaf_fence_t;
endpackage

// ---- sim/gaf_xlat_model.sv ----
module gaf_xlat_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire gaf_pkg::gaf_res_t res_i,
  input wire gaf_pkg::gaf_fence_t fence_i,
  output logic [7:0] flush_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // g-stage fence drops every entry of the vm id, the allowed simplification
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flush_cnt_o <= 8'h00;
    end else if (issue_i && res_i.fence_g && res_i.exc == gaf_pkg::EXC_NONE) begin
      flush_cnt_o <= flush_cnt_o + 8'h01;
    end
  end
endmodule

// ---- sim/guest_access_and_fence_decode_tb_top.sv ----
module guest_access_and_fence_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] C_U = 32'h0, C_HS = 32'h1, C_M = 32'h3, C_V = 32'h4, C_HU = 32'h8;
  localparam logic [31:0] C_SP = 32'h10, C_MX = 32'h40, C_VM = 32'h80, C_R32 = 32'h100;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] flush_cnt;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, issue, err;
  gaf_pkg::gaf_res_t res;
  gaf_pkg::gaf_fence_t fen;
  int mismatches = 0, checks = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  gaf_decoder u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .issue_o(issue), .res_o(res), .fence_o(fen));

  gaf_xlat_model u_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .issue_i(issue),
    .res_i(res), .fence_i(fen), .flush_cnt_o(flush_cnt));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // operands and mode first, then the instruction word
  task automatic run(input logic [31:0] c, input logic [31:0] ins, input logic [31:0] a,
                     input logic [31:0] b);
    apb(1'b1, gaf_pkg::REG_CTRL, c);
    apb(1'b1, gaf_pkg::REG_RS1, a);
    apb(1'b1, gaf_pkg::REG_RS2, b);
    apb(1'b1, gaf_pkg::REG_INSTR, ins);
    @(negedge clk_sys_i);
    chk("issue", 34'h1, {33'h0, issue});
  endtask

  // t = {size, store, rs2 field}
  function automatic logic [31:0] ls(input logic [7:0] t);
    return {4'h6, t[7:5], t[4:0], 5'h01, gaf_pkg::F3_PRIVM, t[5] ? 5'h00 : 5'h05,
            gaf_pkg::OPC_SYSTEM};
  endfunction

  function automatic logic [31:0] fc(input logic g, input logic [9:0] r);
    return {g ? gaf_pkg::F7_GVMA : gaf_pkg::F7_VVMA, r, gaf_pkg::F3_PRIV, 5'h00,
            gaf_pkg::OPC_SYSTEM};
  endfunction

  task automatic t_apb();
    apb(1'b0, gaf_pkg::REG_CTRL, 32'h0);
    chk("ctrl_rst", {2'h0, gaf_pkg::CTRL_RST}, {2'h0, rd});
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk("wr_err", 34'h1, {33'h0, err});
    apb(1'b0, 8'h40, 32'h0);
    chk("rd_err", 34'h1_0000_0000, {1'b0, err, rd});
  endtask

  task automatic t_priv();
    logic [31:0] cv[6] = '{C_M, C_HS, C_U, C_U | C_HU, C_HS | C_V, C_U | C_HU | C_V};
    logic [1:0] ev[6] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2};
    for (int i = 0; i < 6; i++) begin
      run(cv[i], ls(8'h00), 32'h0, 32'h0);
      chk("exc", {32'h0, ev[i]}, {32'h0, res.exc});
    end
  endtask

  task automatic t_width();
    logic [7:0] tab[13] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h80, 8'h81, 8'hC0, 8'h43, 8'h83,
                            8'h22, 8'h62, 8'hA2, 8'hE2};
    logic [7:0] t32[4] = '{8'h81, 8'hC0, 8'hE2, 8'h83};
    logic [1:0] e32[4] = '{2'h1, 2'h1, 2'h1, 2'h0};
    for (int i = 0; i < 13; i++) begin
      run(C_HS | C_SP, ls(tab[i]), 32'h0, 32'h0);
      chk("exc", 34'h0, {32'h0, res.exc});
      chk("kind", {32'h0, ~tab[i][5], tab[i][5]}, {32'h0, res.is_load, res.is_store});
      chk("size", {32'h0, tab[i][7:6]}, {32'h0, res.size});
      chk("uns", {33'h0, tab[i][0]}, {33'h0, res.uns});
      chk("xperm", {32'h0, {2{tab[i][1] & tab[i][0]}}}, {32'h0, res.exec_perm, res.pma_rx});
      chk("stage", 34'h6, {31'h0, res.acc_priv, res.two_stage, res.sum_eff});
    end
    run(C_HS, ls(8'h00), 32'h0, 32'h0);
    chk("priv", 34'h0, {33'h0, res.acc_priv});
    for (int i = 0; i < 4; i++) begin
      run(C_HS | C_R32, ls(t32[i]), 32'h0, 32'h0);
      chk("exc32", {32'h0, e32[i]}, {32'h0, res.exc});
    end
    chk("size32", {32'h0, gaf_pkg::SZ_W}, {32'h0, res.size});
  endtask

  task automatic t_mxr();
    run(C_HS | C_MX, ls(8'h00), 32'h0, 32'h0);
    chk("mxr", 34'h3, {32'h0, res.mxr_vs, res.mxr_g});
    run(C_HS | C_VM, ls(8'h00), 32'h0, 32'h0);
    chk("mxr", 34'h2, {32'h0, res.mxr_vs, res.mxr_g});
  endtask

  // rows are {g-stage, expected exc, ctrl}
  task automatic t_fence();
    logic [11:0] ft[9] = '{12'h003, 12'h021, 12'h200, 12'h405, 12'h823, 12'h801, 12'hA21,
                           12'hA00, 12'hC05};
    for (int i = 0; i < 9; i++) begin
      run({23'h0, ft[i][8:0]}, fc(ft[i][11], 10'h000), 32'h0, 32'h0);
      chk("fexc", {32'h0, ft[i][10:9]}, {32'h0, res.exc});
    end
    chk("flush", 34'h2, {26'h0, flush_cnt});
    run(C_HS | 32'h0005_0000, fc(1'b0, 10'h021), 32'h1234_5678, 32'hFFFF_FFFF);
    chk("scope", 34'h3, {32'h0, fen.by_addr, fen.by_id});
    chk("vaddr", 34'h0_1234_5678, fen.addr);
    chk("asid", 34'h1FF, {18'h0, fen.id});
    chk("vmid", 34'h5, {18'h0, fen.vmid});
    run(C_M, fc(1'b1, 10'h021), 32'hC000_0001, 32'hFFFF_FFFF);
    chk("gaddr", 34'h3_0000_0004, fen.addr);
    chk("gvmid", 34'h7F, {18'h0, fen.id});
    apb(1'b0, gaf_pkg::REG_FADDR, 32'h0);
    chk("faddr", 34'h4, {2'h0, rd});
    apb(1'b0, gaf_pkg::REG_FID, 32'h0);
    chk("fid", 34'h7F, {2'h0, rd});
    run(C_M, fc(1'b1, 10'h000), 32'hC000_0001, 32'h1);
    chk("scope", 34'h0, {32'h0, fen.by_addr, fen.by_id});
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_apb();
    t_priv();
    t_width();
    t_mxr();
    t_fence();
    give_verdict();
  end

  // hang guard, far beyond the expected run
  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule
